// File: common/tbcp_pkg.sv
// shared constants and types for the transmit buffer command parser
// assumes one clock domain and 32-bit words from the transmit data fifo
package tbcp_pkg;

    // ----------------------------------------------------------------
    // command word fields
    // ----------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int LEN_W = 11;
    localparam int A_OFF_LO = 16;
    localparam int A_FS_BIT = 13;
    localparam int A_LS_BIT = 12;
    localparam int B_CK_BIT = 14;
    localparam int B_NOCRC_BIT = 13;
    localparam int B_NOPAD_BIT = 12;
    // checksum request and reserved bits take no part in the compare
    localparam logic [31:0] B_CMP_MASK = 32'h0000_37FF;

    // ----------------------------------------------------------------
    // sizes and reset values
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam logic [3:0] BE_ALL = 4'hF;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [55:0] ACC_RST = 56'h00_0000_0000_0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_CMDA = 3'b000,
        ST_CMDB = 3'b001,
        ST_DATA = 3'b010,
        ST_FLUSH = 3'b011,
        ST_ERR = 3'b100
    } tbcp_state_type;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] be;
        logic last;
        logic csum;
        logic no_crc;
        logic no_pad;
    } tbcp_word_type;

endpackage : tbcp_pkg

// File: hdl/tbcp_parser.sv
// transmit buffer command parser and its output word fifo
// assumes a word stream from the transmit data fifo read side, valid/ready,
// and a mac transmit interface that takes words with byte enables
`timescale 1ns/100ps

// ----------------------------------------------------------------
// output word fifo
// ----------------------------------------------------------------
module tbcp_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic push, pop;
    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule : tbcp_fifo

// Behaviour
// - checksum only with request, first segment, enable
// - crc-suppress bit stops crc append
// - pad-suppress bit stops short-frame padding
// - pad suppression forces crc append anyway
// - frame length is payload bytes only
// - length mismatch raises transmit error flag
// - move exactly frame length bytes out
// - final word carries partial byte enables
// - payload begins after two command words
// - start offset picks first valid lane
// - payload contiguous, buffer ends anywhere
// - trailing unused bytes never forwarded
// - start offset sits in first command bits
// - first command marks first, last segment
// - second command differs, transmit error raised
module tbcp_parser #(
    parameter int FIFO_DEPTH = tbcp_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [31:0] txf_data_i,
    input wire logic txf_valid_i,
    output logic txf_ready_o,
    input wire logic tx_checksum_engine_enable_i,
    input wire logic txe_clear_i,
    output tbcp_pkg::tbcp_word_type mac_word_o,
    output logic mac_valid_o,
    input wire logic mac_ready_i,
    output logic transmit_error_flag_o,
    output logic txe_event_o
);
    // ----------------------------------------------------------------
    // state and storage
    // ----------------------------------------------------------------
    tbcp_pkg::tbcp_state_type state_q;
    logic [31:0] cmda_q, frame_b_q;
    logic in_frame_q, first_word_q, csum_q, txe_q;
    logic [10:0] buf_left_q;
    logic [11:0] got_q;
    logic [55:0] acc_q;
    logic [2:0] cnt_q;
    logic push_v, push_rdy, take, err_a, err_b, mism, buf_end, frame_end;
    tbcp_pkg::tbcp_word_type push_w;
    logic [11:0] tot;
    logic [1:0] lo;
    logic [2:0] avail, n;
    logic [31:0] shifted, bytes;
    logic [3:0] sum, keep;
    logic [55:0] merged;
    function automatic logic [3:0] lane_mask(input logic [2:0] k);
        lane_mask = (k >= 3'd4) ? tbcp_pkg::BE_ALL : 4'((5'h01 << k) - 5'h01);
    endfunction : lane_mask
    assign txf_ready_o = push_rdy && (state_q == tbcp_pkg::ST_CMDA
        || state_q == tbcp_pkg::ST_CMDB || state_q == tbcp_pkg::ST_DATA);
    assign take = txf_valid_i && txf_ready_o;

    // ----------------------------------------------------------------
    // buffer checks
    // ----------------------------------------------------------------
    assign err_a = (in_frame_q == txf_data_i[tbcp_pkg::A_FS_BIT])
        || (txf_data_i[10:0] == 11'h000);
    assign tot = got_q + {1'b0, cmda_q[10:0]};
    // compare only the defined fields
    assign mism = in_frame_q
        && (((txf_data_i ^ frame_b_q) & tbcp_pkg::B_CMP_MASK) != '0);
    assign err_b = mism
        || (cmda_q[tbcp_pkg::A_LS_BIT] != (tot >= {1'b0, txf_data_i[10:0]}))
        || (cmda_q[tbcp_pkg::A_LS_BIT] && tot != {1'b0, txf_data_i[10:0]});

    // ----------------------------------------------------------------
    // byte extraction
    // ----------------------------------------------------------------
    assign lo = first_word_q ? cmda_q[tbcp_pkg::A_OFF_LO +: 2] : 2'b00;
    assign avail = 3'd4 - {1'b0, lo};
    assign n = (buf_left_q < {8'h00, avail}) ? buf_left_q[2:0] : avail;
    assign shifted = txf_data_i >> {lo, 3'b000};
    assign sum = {1'b0, cnt_q} + {1'b0, n};
    assign merged = acc_q | ({24'h00_0000, bytes} << {cnt_q, 3'b000});
    assign buf_end = (buf_left_q == {8'h00, n});
    assign frame_end = buf_end && cmda_q[tbcp_pkg::A_LS_BIT];
    assign keep = lane_mask(n);
    always_comb begin
        bytes = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            if (keep[i]) begin
                bytes[i*8 +: 8] = shifted[i*8 +: 8];
            end
        end
    end

    // ----------------------------------------------------------------
    // output word assembly
    // ----------------------------------------------------------------
    always_comb begin
        push_v = 1'b0;
        push_w.data = 32'h0000_0000;
        push_w.be = 4'h0;
        push_w.last = 1'b0;
        push_w.csum = csum_q;
        // pad suppression overrides crc suppression
        push_w.no_crc = frame_b_q[tbcp_pkg::B_NOCRC_BIT]
            && !frame_b_q[tbcp_pkg::B_NOPAD_BIT];
        push_w.no_pad = frame_b_q[tbcp_pkg::B_NOPAD_BIT];
        case (state_q)
            tbcp_pkg::ST_DATA: begin
                if (take && (sum >= 4'd4 || frame_end)) begin
                    push_v = 1'b1;
                    push_w.data = merged[31:0];
                    push_w.be = lane_mask(sum[3] ? 3'd4 : sum[2:0]);
                    push_w.last = frame_end && sum <= 4'd4;
                end
            end
            tbcp_pkg::ST_FLUSH: begin
                push_v = 1'b1;
                push_w.data = acc_q[31:0];
                push_w.be = lane_mask(cnt_q);
                push_w.last = 1'b1;
            end
            default: begin
                push_v = 1'b0;
            end
        endcase
    end
    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q <= tbcp_pkg::ST_CMDA;
        end else begin
            case (state_q)
                tbcp_pkg::ST_CMDA: begin
                    if (take) begin
                        state_q <= err_a ? tbcp_pkg::ST_ERR : tbcp_pkg::ST_CMDB;
                    end
                end
                tbcp_pkg::ST_CMDB: begin
                    if (take) begin
                        state_q <= err_b ? tbcp_pkg::ST_ERR : tbcp_pkg::ST_DATA;
                    end
                end
                tbcp_pkg::ST_DATA: begin
                    if (take && buf_end) begin
                        state_q <= (frame_end && sum > 4'd4) ? tbcp_pkg::ST_FLUSH
                            : tbcp_pkg::ST_CMDA;
                    end
                end
                tbcp_pkg::ST_FLUSH: begin
                    if (push_rdy) begin
                        state_q <= tbcp_pkg::ST_CMDA;
                    end
                end
                // a broken buffer chain cannot be resynchronised; reset only
                tbcp_pkg::ST_ERR: state_q <= tbcp_pkg::ST_ERR;
                default: state_q <= tbcp_pkg::ST_ERR;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cmda_q <= tbcp_pkg::WORD_RST;
            frame_b_q <= tbcp_pkg::WORD_RST;
            csum_q <= 1'b0;
        end else if (take && state_q == tbcp_pkg::ST_CMDA) begin
            cmda_q <= txf_data_i;
        end else if (take && state_q == tbcp_pkg::ST_CMDB && !in_frame_q) begin
            frame_b_q <= txf_data_i;
            csum_q <= txf_data_i[tbcp_pkg::B_CK_BIT]
                && cmda_q[tbcp_pkg::A_FS_BIT] && tx_checksum_engine_enable_i;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            in_frame_q <= 1'b0;
            first_word_q <= 1'b0;
            buf_left_q <= 11'h000;
            got_q <= 12'h000;
        end else if (take && state_q == tbcp_pkg::ST_CMDB) begin
            buf_left_q <= cmda_q[10:0];
            first_word_q <= 1'b1;
            got_q <= tot;
        end else if (take && state_q == tbcp_pkg::ST_DATA) begin
            first_word_q <= 1'b0;
            buf_left_q <= buf_left_q - {8'h00, n};
            if (buf_end) begin
                in_frame_q <= !cmda_q[tbcp_pkg::A_LS_BIT];
                if (cmda_q[tbcp_pkg::A_LS_BIT]) begin
                    got_q <= 12'h000;
                end
            end
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            acc_q <= tbcp_pkg::ACC_RST;
            cnt_q <= 3'd0;
        end else if (take && state_q == tbcp_pkg::ST_DATA) begin
            if (sum >= 4'd4) begin
                acc_q <= merged >> 32;
                cnt_q <= 3'(sum - 4'd4);
            end else if (frame_end) begin
                acc_q <= tbcp_pkg::ACC_RST;
                cnt_q <= 3'd0;
            end else begin
                acc_q <= merged;
                cnt_q <= sum[2:0];
            end
        end else if (state_q == tbcp_pkg::ST_FLUSH && push_rdy) begin
            acc_q <= tbcp_pkg::ACC_RST;
            cnt_q <= 3'd0;
        end
    end

    // ----------------------------------------------------------------
    // error flag
    // ----------------------------------------------------------------
    assign txe_event_o = take && ((state_q == tbcp_pkg::ST_CMDA && err_a)
        || (state_q == tbcp_pkg::ST_CMDB && err_b));
    // a new error in the clearing cycle keeps the flag set
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            txe_q <= 1'b0;
        end else if (txe_event_o) begin
            txe_q <= 1'b1;
        end else if (txe_clear_i) begin
            txe_q <= 1'b0;
        end
    end
    assign transmit_error_flag_o = txe_q;

    // ----------------------------------------------------------------
    // output buffering
    // ----------------------------------------------------------------
    tbcp_fifo #(
        .WIDTH($bits(tbcp_pkg::tbcp_word_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .in_data_i(push_w),
        .in_valid_i(push_v),
        .in_ready_o(push_rdy),
        .out_data_o(mac_word_o),
        .out_valid_o(mac_valid_o),
        .out_ready_i(mac_ready_i)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    property p_pad_forces_crc;
        push_v && push_w.no_pad |-> !push_w.no_crc;
    endproperty
    a_pad_forces_crc: assert property (p_pad_forces_crc)
        else $error("crc suppressed while padding suppressed");
    property p_csum_needs_enable;
        take && state_q == tbcp_pkg::ST_CMDB && !in_frame_q
            && !tx_checksum_engine_enable_i |=> !csum_q;
    endproperty
    a_csum_needs_enable: assert property (p_csum_needs_enable)
        else $error("checksum requested without engine enable");
    property p_full_mid_words;
        push_v && !push_w.last |-> push_w.be == tbcp_pkg::BE_ALL;
    endproperty
    a_full_mid_words: assert property (p_full_mid_words)
        else $error("partial enables before last word");
    property p_contig_be;
        push_v |-> push_w.be inside {4'h1, 4'h3, 4'h7, 4'hF};
    endproperty
    a_contig_be: assert property (p_contig_be)
        else $error("byte enables not contiguous from lane 0");
    property p_len_error;
        take && state_q == tbcp_pkg::ST_CMDB && cmda_q[tbcp_pkg::A_LS_BIT]
            && tot != {1'b0, txf_data_i[10:0]} |=> txe_q && state_q == tbcp_pkg::ST_ERR;
    endproperty
    a_len_error: assert property (p_len_error)
        else $error("length mismatch not flagged");
    property p_cmdb_mismatch;
        take && state_q == tbcp_pkg::ST_CMDB && in_frame_q
            && txf_data_i[10:0] != frame_b_q[10:0] |=> txe_q;
    endproperty
    a_cmdb_mismatch: assert property (p_cmdb_mismatch)
        else $error("second command change not flagged");
    // defined fields equal: checksum and reserved bits may differ freely
    property p_ck_ignored;
        take && state_q == tbcp_pkg::ST_CMDB && in_frame_q
            && txf_data_i[13:12] == frame_b_q[13:12]
            && txf_data_i[10:0] == frame_b_q[10:0] |-> !mism;
    endproperty
    a_ck_ignored: assert property (p_ck_ignored)
        else $error("checksum or reserved bit counted as mismatch");
    property p_cmd_then_data;
        take && state_q == tbcp_pkg::ST_CMDA && !err_a
            |=> state_q == tbcp_pkg::ST_CMDB ##0 !push_v;
    endproperty
    a_cmd_then_data: assert property (p_cmd_then_data)
        else $error("command word not followed by second command");
    property p_err_stalls;
        state_q == tbcp_pkg::ST_ERR |-> !txf_ready_o ##1 state_q == tbcp_pkg::ST_ERR;
    endproperty
    a_err_stalls: assert property (p_err_stalls)
        else $error("parser resumed after error");
    c_frame_done: cover property (push_v && push_w.last && push_w.be == 4'h1);
    c_flush: cover property (state_q == tbcp_pkg::ST_FLUSH ##1 state_q == tbcp_pkg::ST_CMDA);
    c_multi_buf: cover property (take && state_q == tbcp_pkg::ST_CMDB && in_frame_q);
    c_error: cover property (txe_event_o);

endmodule : tbcp_parser

// File: tb/tb_top.sv
// testbench for the transmit buffer command parser
// assumes the mac model in tb/ and the design package in common/
`timescale 1ns/100ps
module tb_top;
    localparam int DLY = 2;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [31:0] txf_data_i = 32'h0000_0000;
    logic txf_valid_i = 1'b0;
    logic txf_ready_o;
    logic csum_en = 1'b0;
    logic txe_clear_i = 1'b0;
    tbcp_pkg::tbcp_word_type mac_word_o;
    logic mac_valid_o;
    logic mac_ready;
    logic transmit_error_flag_o;
    logic txe_event_o;
    logic [1:0] mode = 2'h0;
    int error_cnt = 0;
    int tests_run = 0;
    int ev_cnt = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    tbcp_parser i_tbcp_parser (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .txf_data_i(txf_data_i),
        .txf_valid_i(txf_valid_i), .txf_ready_o(txf_ready_o),
        .tx_checksum_engine_enable_i(csum_en), .txe_clear_i(txe_clear_i),
        .mac_word_o(mac_word_o), .mac_valid_o(mac_valid_o), .mac_ready_i(mac_ready),
        .transmit_error_flag_o(transmit_error_flag_o), .txe_event_o(txe_event_o)
    );

    tbcp_mac_model i_tbcp_mac_model (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .mode_i(mode),
        .mac_word_i(mac_word_o), .mac_valid_i(mac_valid_o), .mac_ready_o(mac_ready)
    );

    always @(posedge ref_clk_i) begin
        if (txe_event_o === 1'b1) ev_cnt++;
    end

    // ------------------------------------------
    // helpers
    // ------------------------------------------
    task check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task stop_test;
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    task cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #DLY;
    endtask : cyc

    function logic [7:0] pat(input int k);
        return k[7:0] ^ 8'hA5;
    endfunction : pat

    // reserved bits set on purpose: they must not matter
    function logic [31:0] cmd_b(input logic ck, input logic ncrc, input logic npad,
                                input int len);
        return 32'hFFFF_8800 | {17'h0, ck, ncrc, npad, 1'b0, len[10:0]};
    endfunction : cmd_b

    task send_word(input logic [31:0] w);
        int n;
        n = 0;
        txf_data_i = w;
        txf_valid_i = 1'b1;
        while (txf_ready_o !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        check(txf_ready_o, 1'b1);
        cyc(1);
    endtask : send_word

    // filler bytes outside the buffer are 0xEE so a leak shows
    task send_buf(input int off, input logic fs, input logic ls, input int size,
                  input logic [31:0] cmdb, input int base);
        logic [31:0] w;
        int p;
        w = 32'h0000_0000;
        w[17:16] = off[1:0];
        w[13] = fs;
        w[12] = ls;
        w[10:0] = size[10:0];
        send_word(w);
        send_word(cmdb);
        for (int i = 0; i < (off + size + 3) / 4; i++) begin
            for (int j = 0; j < 4; j++) begin
                p = i * 4 + j - off;
                w[j*8+:8] = (p >= 0 && p < size) ? pat(base + p) : 8'hEE;
            end
            send_word(w);
        end
    endtask : send_buf

    task check_frame(input int len, input logic cs, input logic ncrc, input logic npad);
        tbcp_pkg::tbcp_word_type got;
        logic [31:0] m;
        logic [3:0] be;
        int nw;
        int n;
        nw = (len + 3) / 4;
        n = 0;
        while (i_tbcp_mac_model.rx_q.size() < nw && n < 2000) begin
            cyc(1);
            n++;
        end
        check(i_tbcp_mac_model.rx_q.size() >= nw, 1'b1);
        for (int i = 0; i < nw; i++) begin
            got = i_tbcp_mac_model.rx_q.pop_front();
            be = (i < nw - 1 || len % 4 == 0) ? 4'hF : 4'hF >> (4 - len % 4);
            for (int j = 0; j < 4; j++) begin
                m[j*8+:8] = be[j] ? pat(i * 4 + j) : 8'h00;
            end
            check(got.be, be);
            check(got.data & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}, m);
            check(got.last, i == nw - 1);
            check({got.csum, got.no_crc, got.no_pad}, {cs, ncrc, npad});
        end
        cyc(2);
        check(i_tbcp_mac_model.rx_q.size(), 0);
    endtask : check_frame

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task t_offsets;
        for (int off = 0; off < 4; off++) begin
            csum_en = off[0];
            send_buf(off, 1'b1, 1'b1, 5 + off, cmd_b(1'b1, off[1], off[0], 5 + off), 0);
            txf_valid_i = 1'b0;
            check_frame(5 + off, off[0], off[1] & ~off[0], off[0]);
        end
        $display("test offsets done");
    endtask : t_offsets

    task t_multi;
        mode = 2'h1;
        csum_en = 1'b1;
        send_buf(3, 1'b1, 1'b0, 2, cmd_b(1'b1, 1'b0, 1'b0, 11), 0);
        send_buf(1, 1'b0, 1'b0, 4, cmd_b(1'b0, 1'b0, 1'b0, 11) ^ 32'h5A5A_0000, 2);
        send_buf(2, 1'b0, 1'b1, 5, cmd_b(1'b0, 1'b0, 1'b0, 11), 6);
        txf_valid_i = 1'b0;
        check_frame(11, 1'b1, 1'b0, 1'b0);
        check(transmit_error_flag_o, 1'b0);
        mode = 2'h0;
        $display("test multi done");
    endtask : t_multi

    task t_fill;
        mode = 2'h2;
        csum_en = 1'b0;
        // drop valid as soon as the last word is taken, or it is taken again
        fork
            begin
                send_buf(0, 1'b1, 1'b1, 80, cmd_b(1'b0, 1'b0, 1'b0, 80), 0);
                txf_valid_i = 1'b0;
            end
        join_none
        cyc(40);
        check(txf_ready_o, 1'b0);
        check(mac_valid_o, 1'b1);
        mode = 2'h0;
        check_frame(80, 1'b0, 1'b0, 1'b0);
        wait fork;
        check(mac_valid_o, 1'b0);
        check(transmit_error_flag_o, 1'b0);
        $display("test fill done");
    endtask : t_fill

    // 0 missing first segment, 1 length short, 2 second command differs, 3 size zero
    task t_err(input int kind);
        reset_i = 1'b1;
        txf_valid_i = 1'b0;
        cyc(6);
        reset_i = 1'b0;
        ev_cnt = 0;
        if (kind == 0) begin
            send_word(32'h0000_1005);
        end else if (kind == 1) begin
            send_word(32'h0000_3005);
            send_word(cmd_b(1'b0, 1'b0, 1'b0, 7));
        end else if (kind == 2) begin
            send_buf(0, 1'b1, 1'b0, 4, cmd_b(1'b0, 1'b0, 1'b0, 8), 0);
            send_word(32'h0000_1004);
            send_word(cmd_b(1'b0, 1'b1, 1'b0, 8));
        end else begin
            send_word(32'h0000_2000);
        end
        txf_valid_i = 1'b0;
        cyc(2);
        check(ev_cnt, 1);
        check(transmit_error_flag_o, 1'b1);
        check(txf_ready_o, 1'b0);
        txe_clear_i = 1'b1;
        cyc(1);
        txe_clear_i = 1'b0;
        cyc(1);
        check(transmit_error_flag_o, 1'b0);
        $display("test error %0d done", kind);
    endtask : t_err

    initial begin
        cyc(6);
        reset_i = 1'b0;
        t_offsets;
        t_multi;
        t_fill;
        for (int k = 0; k < 4; k++) t_err(k);
        stop_test;
    end

    // whole run needs well under a few thousand cycles
    initial begin
        cyc(20000);
        error_cnt++;
        $display("watchdog expired at %0t", $time);
        stop_test;
    end
endmodule : tb_top

// File: tb/tbcp_mac_model.sv
// mac transmit side model: takes parser output words into a queue
// assumes the parser's clock and reset; mode 0 prompt, 1 slow, 2 stalled
`timescale 1ns/100ps
module tbcp_mac_model (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [1:0] mode_i,
    input wire tbcp_pkg::tbcp_word_type mac_word_i,
    input wire logic mac_valid_i,
    output logic mac_ready_o
);
    tbcp_pkg::tbcp_word_type rx_q[$];
    logic [1:0] tick_q;

    // ------------------------------------------
    // acceptance pattern
    // ------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tick_q <= 2'h0;
        end else begin
            tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        mac_ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && tick_q == 2'h1);
    end

    // ------------------------------------------
    // capture
    // ------------------------------------------
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_q.delete();
        end else if (mac_valid_i === 1'b1 && mac_ready_o === 1'b1) begin
            rx_q.push_back(mac_word_i);
        end
    end
endmodule : tbcp_mac_model
